// ===== verilog/scev_consts.vh
// Constants for the system control and exception vectoring block
// Functional notes
// - User flag select 0 makes aux mask bit a mask; 1 makes it a free flag.
// - Edge select 0 takes falling nonmaskable edge, 1 rising; reset value 0.
// - Reserved control bit is read-only and always reads 1.
// - RAM enable 0 sends RAM addresses external, 1 enables; resets to 1.
// - RAM enable reinitialised at reset release, kept through software standby.
// - Modes 1 and 3 start 8-bit bus; any 16-bit area switches to 16-bit.
// - Modes 2 and 4 start 16-bit bus; all areas 8-bit switches to 8-bit.
// - Modes 1 and 2 use 20 address lines; modes 3 and 4 use 24.
// - Upper port 5 pins are port bits in modes 1, 2; high address in 3, 4.
// - Port 4 pins are port bits in 8-bit bus mode, low data byte in 16-bit.
// - Priority: reset, then interrupts, then traps; simultaneous ones taken in order.
// - Trap always accepted during program execution, regardless of mask bits.
// - Reset handling begins right after the reset pin rises.
// - Pending interrupt taken only after current instruction or exception completes.
// - Interrupts and traps: stack PC and condition codes, set mask, vector, then run.
// - Reset skips stacking: sets mask bit, fetches reset vector.
// - Vectors: reset 0, nonmaskable 7, external 12 to 19, internal 20 to 53.
// - Vector numbers 1 to 6 are never used by any source.
// - Four trap variants map to vectors 8 to 11 by trap number field.
// - Vector entry is four bytes at vector number times four.
// - Accept 34 distinct internal requests, each with its own vector.
// - Trap with user flag select 1 sets main mask only; 0 sets both.
// - After reset all interrupts, nonmaskable too, blocked until first instruction executes; traps are not.
`ifndef SCEV_CONSTS_VH
`define SCEV_CONSTS_VH
`define SCEV_ADDR_SYSCTL 4'h0
`define SCEV_ADDR_STATUS 4'h4
`define SCEV_ADDR_AREAW 4'h8
`define SCEV_ADDR_VECTOR 4'hc
`define SCEV_SYSCTL_RESET 8'h0b
`define SCEV_BIT_UFS 3
`define SCEV_BIT_EDGE_SEL 2
`define SCEV_BIT_RSVD 1
`define SCEV_BIT_RAM_ON 0
`define SCEV_VEC_RESET 6'd0
`define SCEV_VEC_NMI 6'd7
`define SCEV_VEC_TRAP0 6'd8
`define SCEV_VEC_IRQ0 6'd12
`define SCEV_VEC_INT0 6'd20
`define SCEV_NUM_INT 34
`define SCEV_STACK_CYC 4'd4
`define SCEV_FETCH_CYC 4'd4
`endif

// ===== verilog/scev_top.v
// System control register, mode decode and exception sequencer
`default_nettype none
`include "scev_consts.vh"
module scev_top #(
  parameter NINT = `SCEV_NUM_INT
) (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Mode and standby
  input wire [2:0] mode_select_pins,
  input wire soft_standby,
  // Exception sources
  input wire nmi_pin,
  input wire [7:0] irq_req,
  input wire [NINT-1:0] int_req,
  input wire soft_trap_instr,
  input wire [1:0] trap_num,
  input wire instr_done,
  input wire first_instr_done,
  // Core hand-off
  input wire [7:0] condition_code_reg,
  input wire vec_data_valid,
  input wire [31:0] vec_data,
  output reg stack_req,
  output reg fetch_req,
  output reg [15:0] vector_addr,
  output reg set_mask_main,
  output reg set_mask_aux,
  output reg pc_load,
  output reg [31:0] pc_value,
  output reg exc_busy,
  output reg int_ack,
  output reg [5:0] int_ack_vec,
  // Mode outputs
  output reg [4:0] addr_width_m1,
  output reg bus16,
  output reg port5_is_addr,
  output reg port4_is_data,
  output reg onchip_ram_on
);
  // Sequencer states, one-hot
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_STACK = 5'h02;
  localparam [4:0] ST_MASK = 5'h04;
  localparam [4:0] ST_FETCH = 5'h08;
  localparam [4:0] ST_RUN = 5'h10;

  reg [7:0] sysctl_r;
  reg [7:0] area_width_register;
  reg [2:0] mode_r;
  reg nmi_d_r;
  reg nmi_pend_r;
  reg reset_pend_r;
  reg blocked_r;
  reg [4:0] state_r;
  reg [3:0] cnt_r;
  reg [5:0] vec_r;
  reg is_reset_r;
  reg is_trap_r;
  reg ack_r;
  reg rd_ok_r;
  reg [5:0] sel_vec;
  reg sel_valid;
  reg sel_int;
  reg [5:0] vec_nxt;
  integer k;

  wire wr = avs_write & clk_en;
  wire ufs = sysctl_r[`SCEV_BIT_UFS];
  wire mask_i = condition_code_reg[7];
  wire mask_aux = condition_code_reg[6] & ~ufs;
  wire nmi_edge = sysctl_r[`SCEV_BIT_EDGE_SEL] ? (nmi_pin & ~nmi_d_r) :
                  (~nmi_pin & nmi_d_r);
  wire mode_odd = (mode_r == 3'd1) | (mode_r == 3'd3);
  wire mode_big = (mode_r == 3'd3) | (mode_r == 3'd4);
  wire maskable = |irq_req | (|int_req);

  // Reads wait one cycle for registered data; all requests wait while frozen
  assign avs_waitrequest = (avs_read & ~rd_ok_r) | (~clk_en & (avs_read | avs_write));

  // Register writes and standby-safe RAM enable
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sysctl_r <= `SCEV_SYSCTL_RESET;
      area_width_register <= 8'h00;
      mode_r <= 3'd0;
    end else if (clk_en) begin
      if (state_r == ST_IDLE && reset_pend_r) begin
        mode_r <= mode_select_pins;
        area_width_register <= (mode_select_pins == 3'd2 || mode_select_pins == 3'd4) ?
                               8'hff : 8'h00;
      end
      // Standby does not touch the register
      if (wr && avs_address == `SCEV_ADDR_SYSCTL)
        sysctl_r <= {avs_writedata[7:2], 1'b1, avs_writedata[0]};
      if (wr && avs_address == `SCEV_ADDR_AREAW)
        area_width_register <= avs_writedata[7:0];
    end
  end

  // Mode decode for pins and bus width
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_width_m1 <= 5'd19;
      bus16 <= 1'b0;
      port5_is_addr <= 1'b0;
      port4_is_data <= 1'b0;
      onchip_ram_on <= 1'b1;
    end else if (clk_en) begin
      addr_width_m1 <= mode_big ? 5'd23 : 5'd19;
      port5_is_addr <= mode_big;
      // Any 16-bit area gives a 16-bit bus; all 8-bit gives 8-bit
      bus16 <= |area_width_register;
      port4_is_data <= |area_width_register;
      onchip_ram_on <= sysctl_r[`SCEV_BIT_RAM_ON];
    end
  end

  // Read mux
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
      rd_ok_r <= 1'b0;
    end else if (clk_en) begin
      // One wait state so the data stand at the accepting edge
      rd_ok_r <= avs_read & ~rd_ok_r;
      if (avs_read && !rd_ok_r) case (avs_address)
        `SCEV_ADDR_SYSCTL: avs_readdata <= {24'h0, sysctl_r[7:2], 1'b1, sysctl_r[0]};
        `SCEV_ADDR_STATUS: avs_readdata <= {16'h0, 3'h0, state_r, mode_r, bus16,
                                            blocked_r, nmi_pend_r, exc_busy, mode_odd};
        `SCEV_ADDR_AREAW: avs_readdata <= {24'h0, area_width_register};
        `SCEV_ADDR_VECTOR: avs_readdata <= {26'h0, vec_r};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // Source selection: NMI, then external, then internal, then trap
  always @* begin
    sel_vec = `SCEV_VEC_RESET;
    sel_valid = 1'b0;
    sel_int = 1'b0;
    for (k = NINT - 1; k >= 0; k = k - 1) begin
      if (int_req[k] && !mask_i && !mask_aux) begin
        sel_vec = `SCEV_VEC_INT0 + k[5:0];
        sel_valid = 1'b1;
        sel_int = 1'b1;
      end
    end
    for (k = 7; k >= 0; k = k - 1) begin
      if (irq_req[k] && !mask_i && !mask_aux) begin
        sel_vec = `SCEV_VEC_IRQ0 + k[5:0];
        sel_valid = 1'b1;
        sel_int = 1'b1;
      end
    end
    if (nmi_pend_r) begin
      sel_vec = `SCEV_VEC_NMI;
      sel_valid = 1'b1;
      sel_int = 1'b1;
    end
    if (blocked_r) begin
      sel_valid = 1'b0;
      sel_int = 1'b0;
    end
    // Interrupts wait for instruction boundary; traps are unmasked
    if (!instr_done) begin
      sel_valid = 1'b0;
      sel_int = 1'b0;
    end
    if (!sel_int && soft_trap_instr) begin
      sel_vec = `SCEV_VEC_TRAP0 + {4'h0, trap_num};
      sel_valid = 1'b1;
    end
    vec_nxt = sel_vec;
  end

  // Exception sequencer
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      vec_r <= 6'h0;
      is_reset_r <= 1'b0;
      is_trap_r <= 1'b0;
      reset_pend_r <= 1'b1;
      blocked_r <= 1'b1;
      nmi_d_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      ack_r <= 1'b0;
      stack_req <= 1'b0;
      fetch_req <= 1'b0;
      vector_addr <= 16'h0;
      set_mask_main <= 1'b0;
      set_mask_aux <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= 32'h0;
      exc_busy <= 1'b0;
      int_ack <= 1'b0;
      int_ack_vec <= 6'h0;
    end else if (clk_en) begin
      nmi_d_r <= nmi_pin;
      set_mask_main <= 1'b0;
      set_mask_aux <= 1'b0;
      pc_load <= 1'b0;
      int_ack <= 1'b0;
      // Edge capture; a new edge wins over the acceptance clear
      // Edges during the post-reset block are dropped, so no false edge
      if (nmi_edge && !blocked_r)
        nmi_pend_r <= 1'b1;
      else if (ack_r)
        nmi_pend_r <= 1'b0;
      ack_r <= 1'b0;
      if (first_instr_done)
        blocked_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (reset_pend_r) begin
            // Reset goes first and skips stacking
            reset_pend_r <= 1'b0;
            is_reset_r <= 1'b1;
            is_trap_r <= 1'b0;
            vec_r <= `SCEV_VEC_RESET;
            exc_busy <= 1'b1;
            state_r <= ST_MASK;
          end else if (sel_valid) begin
            is_reset_r <= 1'b0;
            is_trap_r <= !sel_int;
            vec_r <= vec_nxt;
            ack_r <= (vec_nxt == `SCEV_VEC_NMI);
            int_ack <= sel_int;
            int_ack_vec <= vec_nxt;
            exc_busy <= 1'b1;
            stack_req <= 1'b1;
            cnt_r <= `SCEV_STACK_CYC;
            state_r <= ST_STACK;
          end
        end
        ST_STACK: begin
          if (cnt_r == 4'h1) begin
            stack_req <= 1'b0;
            state_r <= ST_MASK;
          end
          cnt_r <= cnt_r - 4'h1;
        end
        ST_MASK: begin
          set_mask_main <= 1'b1;
          set_mask_aux <= is_trap_r ? ~ufs : 1'b0;
          vector_addr <= {8'h00, vec_r, 2'b00};
          fetch_req <= 1'b1;
          state_r <= ST_FETCH;
        end
        ST_FETCH: begin
          if (vec_data_valid) begin
            fetch_req <= 1'b0;
            pc_value <= vec_data;
            pc_load <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          exc_busy <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // scev_top
`default_nettype wire

// ===== sim/scev_top_asserts.sv
// Port assertions for the exception vectoring top
`default_nettype none
module scev_top_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic stack_req,
  input wire logic set_mask_main,
  input wire logic fetch_req,
  input wire logic [15:0] vector_addr,
  input wire logic vec_data_valid,
  input wire logic [31:0] vec_data,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic int_ack,
  input wire logic [5:0] int_ack_vec,
  input wire logic instr_done,
  input wire logic [4:0] addr_width_m1,
  input wire logic bus16,
  input wire logic port5_is_addr,
  input wire logic port4_is_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  rsvd_one_a:
    assert property (avs_read && avs_address == 4'h0 |=> avs_readdata[1]) else $error("rsvd bit");
  stack_len_a:
    assert property ($rose(stack_req) |-> stack_req [*4] ##1 !stack_req) else $error("stack len");
  mask_after_a:
    assert property ($fell(stack_req) |-> ##1 set_mask_main) else $error("mask late");
  pc_from_vec_a:
    assert property (vec_data_valid && fetch_req |=> pc_load && pc_value == $past(vec_data))
      else $error("pc load");
  vec_addr_ok_a:
    assert property (fetch_req |-> vector_addr[1:0] == 2'b00 && vector_addr[15:8] == 8'h00
      && !(vector_addr inside {[16'h0004:16'h001b]})) else $error("vec addr");
  ack_range_a:
    assert property (int_ack |-> int_ack_vec >= 6'd7 && int_ack_vec <= 6'd60) else $error("vec num");
  irq_boundary_a:
    assert property (int_ack && int_ack_vec >= 6'd12 |-> $past(instr_done)) else $error("mid instr");
  addr_lines_a:
    assert property (addr_width_m1 == 5'd19 || addr_width_m1 == 5'd23) else $error("addr width");
  port5_role_a:
    assert property (port5_is_addr == (addr_width_m1 == 5'd23)) else $error("port5 role");
  port4_role_a:
    assert property (port4_is_data == bus16) else $error("port4 role");
endmodule // scev_top_asserts
bind scev_top scev_top_asserts u_chk (.*);
`default_nettype wire

// ===== sim/scev_core_model.sv
// Core model answering vector fetches
`default_nettype none
module scev_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fetch_req,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] lag,
  output logic vec_data_valid,
  output logic [31:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  // Answer after lag cycles, scramble data otherwise
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 4'h0;
      vec_data_valid <= 1'b0;
      vec_data <= 32'h0;
    end else if (fetch_req && !vec_data_valid && wait_r == lag) begin
      vec_data_valid <= 1'b1;
      vec_data <= {16'h5a5a, vector_addr};
      wait_r <= 4'h0;
    end else begin
      vec_data_valid <= 1'b0;
      vec_data <= ~vec_data;
      wait_r <= fetch_req ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule // scev_core_model
`default_nettype wire

// ===== sim/system_control_exception_vectoring_test.sv
// Testbench for system control and exception vectoring
`default_nettype none
module system_control_exception_vectoring_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, nrst, clk_en, avs_read, avs_write, avs_waitrequest, soft_standby, nmi_pin;
  logic soft_trap_instr, instr_done, first_instr_done, vec_data_valid, stack_req, fetch_req;
  logic set_mask_main, set_mask_aux, pc_load, exc_busy, int_ack, bus16, port5_is_addr;
  logic port4_is_data, onchip_ram_on, hits;
  logic [3:0] avs_address, lag;
  logic [31:0] avs_writedata, avs_readdata, vec_data, pc_value, rd;
  logic [2:0] mode_select_pins;
  logic [7:0] irq_req, condition_code_reg;
  logic [33:0] int_req;
  logic [1:0] trap_num;
  logic [15:0] vector_addr;
  logic [5:0] int_ack_vec;
  logic [4:0] addr_width_m1;
  int fail_count = 0;
  int compares = 0;
  scev_top u_dut (.*);
  scev_core_model u_core (.*);
  // Clock
  always #50 ref_clk = ~ref_clk;
  task report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task step(inout int n);
    @(negedge ref_clk);
    n++;
    if (n > 300) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  // Avalon access, read data in rd
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      report_and_stop;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task seq(input logic [5:0] v, input logic aux);
    int n;
    n = 0;
    while (fetch_req !== 1'b1) step(n);
    chk(vector_addr, {8'h00, v, 2'b00}, "vec_addr");
    chk(set_mask_main, 1'b1, "mask_main");
    chk(set_mask_aux, aux, "mask_aux");
    while (pc_load !== 1'b1) step(n);
    chk(pc_value, {16'h5a5a, 8'h00, v, 2'b00}, "pc");
    @(posedge ref_clk);
  endtask
  task exc(input logic [5:0] v, input logic isint, input logic aux);
    int n;
    n = 0;
    while (stack_req !== 1'b1) step(n);
    chk(int_ack, isint, "ack");
    if (isint) chk(int_ack_vec, v, "ack_vec");
    @(posedge ref_clk);
    irq_req <= 8'h00;
    int_req <= 34'h0;
    soft_trap_instr <= 1'b0;
    seq(v, aux);
  endtask
  task quiet(input string nm);
    hits = 1'b0;
    repeat (10) begin
      @(negedge ref_clk);
      hits = hits | int_ack;
    end
    chk(hits, 1'b0, nm);
    @(posedge ref_clk);
  endtask
  // Main sequence
  initial begin
    {ref_clk, nrst, avs_read, avs_write, soft_standby, soft_trap_instr, hits} = 7'h00;
    {instr_done, first_instr_done, irq_req, int_req, trap_num, condition_code_reg, lag} = 0;
    {avs_address, avs_writedata} = 0;
    {clk_en, nmi_pin} = 2'h3;
    mode_select_pins = 3'h1;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    seq(6'd0, 1'b0);
    chk({addr_width_m1, port5_is_addr, bus16}, 7'h4c, "mode1");
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0b, "sysctl");
    bus(1'b1, 4'h0, 32'h0);
    soft_standby <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h02, "rsvd");
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped");
    bus(1'b1, 4'h8, 32'h01);
    @(negedge ref_clk);
    chk({bus16, port4_is_data}, 2'h3, "bus16");
    @(posedge ref_clk);
    irq_req <= 8'h08;
    instr_done <= 1'b1;
    quiet("blocked");
    instr_done <= 1'b0;
    first_instr_done <= 1'b1;
    @(posedge ref_clk);
    first_instr_done <= 1'b0;
    quiet("midinstr");
    instr_done <= 1'b1;
    exc(6'd15, 1'b1, 1'b0);
    condition_code_reg <= 8'hc0;
    nmi_pin <= 1'b0;
    exc(6'd7, 1'b1, 1'b0);
    lag <= 4'h3;
    for (int t = 0; t < 4; t++) begin
      trap_num <= t[1:0];
      soft_trap_instr <= 1'b1;
      exc(6'd8 + t[5:0], 1'b0, 1'b1);
    end
    condition_code_reg <= 8'h00;
    irq_req <= 8'h01;
    int_req <= 34'h1;
    soft_trap_instr <= 1'b1;
    exc(6'd12, 1'b1, 1'b0);
    int_req <= {1'b1, 33'h0};
    exc(6'd53, 1'b1, 1'b0);
    condition_code_reg <= 8'h40;
    irq_req <= 8'h04;
    quiet("auxmask");
    bus(1'b1, 4'h0, 32'h08);
    exc(6'd14, 1'b1, 1'b0);
    trap_num <= 2'h1;
    soft_trap_instr <= 1'b1;
    exc(6'd9, 1'b0, 1'b0);
    nrst <= 1'b0;
    mode_select_pins <= 3'h4;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    seq(6'd0, 1'b0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0b, "ram_reinit");
    chk({addr_width_m1, port5_is_addr, bus16}, 7'h5f, "mode4");
    bus(1'b1, 4'h8, 32'h0);
    @(negedge ref_clk);
    chk({bus16, port4_is_data}, 2'h0, "bus8");
    report_and_stop;
  end
endmodule // system_control_exception_vectoring_test
`default_nettype wire
